// ==== rtl/tosr_sync.sv ====
// Purpose: Two-stage synchroniser for a bus of pin levels.
// Assumes: Each bit is a slow level; multi-bit codes may tear for one cycle.
// Notes: Stage one feeds stage two only.
`timescale 1ns/1ps
module tosr_sync #(
    parameter int W = 1
) (
    // Clock, reset and enable
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else if (ce_i) begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule : tosr_sync

// ==== rtl/tosr_top.sv ====
// Purpose: Answers explicit read requests on the health of four test outputs.
// Assumes: Requests are parsed upstream on clk_i; health levels come from pins.
// Notes: One reply is held at a time; a request waits while a reply is pending.
`timescale 1ns/1ps
// What this block does
// - Class 307 attribute 68 read returns 00 normal or 01 error per output.
// - Class 307 attribute 76 read returns the output's error cause byte.
// - Class 308 instance 1 attribute 69 returns OR of all four errors.
// - Every reply carries general status then additional status byte.
// - Additional status is FF when no detail applies.
// - Successful service answers general status 00.
// - Connection failure answers 01; lost connection answers 07.
// - Resources unavailable answers 02.
// - Invalid parameter answers 20, never the older 03.
// - Path segment error answers 04 and stops path handling.
// - Unknown class, instance or element answers 05 and stops.
// - Partial transfer answers 06.
// - Unsupported service answers 08.
// - Invalid attribute data answers 09.
// - Attribute list entry with non-zero status answers 0A.
// - Object already in requested mode answers 0B.
// - Object unable to serve in present state answers 0C.
// - Creating an existing instance answers 0D.
// - Modifying a fixed attribute answers 0E.
// - Failed privilege check answers 0F.
module tosr_top
    import tosr_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // Test output health pins
    input wire logic [3:0] out_err_i,
    input wire logic [31:0] out_cause_i,
    // Request
    input wire logic req_valid_i,
    input wire tosr_req_t req_i,
    output logic req_ready_o,
    // Reply
    output logic rsp_valid_o,
    output tosr_rsp_t rsp_o,
    input wire logic rsp_ready_i,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp
);
    logic [3:0] err_s;
    logic [31:0] cause_s;
    logic [1:0] ctrl_q;
    logic rsp_valid_q;
    tosr_rsp_t rsp_q;
    tosr_rsp_t rsp_d;
    logic [7:0] last_gs_q;
    logic [31:0] req_cnt_q;
    logic [31:0] err_cnt_q;
    logic req_fire;
    logic rsp_fire;
    logic [1:0] req_idx;
    logic sel_err;
    logic [7:0] sel_cause;
    logic clr_cnt;

    tosr_sync #(.W(36)) tosr_sync_i (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .d_i({out_err_i, out_cause_i}),
        .q_o({err_s, cause_s})
    );

    // Builds the whole reply for one request, highest priority first
    function automatic tosr_rsp_t tosr_decode(
        input tosr_req_t r,
        input logic [3:0] errs,
        input logic [31:0] causes,
        input logic [1:0] ctrl
    );
        tosr_rsp_t o;
        logic [1:0] idx;
        logic per_out;
        logic or_path;
        logic path_ok;
        o.gen_status = GS_SUCCESS;
        o.add_status = ADD_NONE;
        o.data = FLAG_NORMAL;
        o.has_data = 1'b0;
        idx = r.instance_id[1:0] - 2'd1;
        per_out = (r.class_id == CLS_TEST_OUT) && (r.instance_id >= INST_FIRST)
            && (r.instance_id <= INST_LAST)
            && ((r.attribute_id == ATTR_NORMAL_FLAG) || (r.attribute_id == ATTR_ERR_CAUSE));
        or_path = (r.class_id == CLS_TEST_OR) && (r.instance_id == INST_OR)
            && (r.attribute_id == ATTR_OR_FLAG);
        path_ok = per_out || or_path;
        if (r.cond.conn_lost) begin
            o.gen_status = GS_CONN_LOST;
        end else if (r.cond.conn_fail) begin
            o.gen_status = GS_CONN_FAIL;
        end else if (r.cond.path_seg_err) begin
            o.gen_status = GS_PATH_SEG;
        end else if (!path_ok) begin
            o.gen_status = GS_DEST_UNKNOWN;
        end else if (r.cond.resource_busy || ctrl[CTRL_BUSY_BIT]) begin
            o.gen_status = GS_RESOURCE;
        end else if (r.cond.privilege_fail) begin
            o.gen_status = GS_PRIVILEGE;
        end else if (r.service != SVC_GET_SINGLE) begin
            o.gen_status = GS_SVC_UNSUPP;
        end else if (r.cond.state_conflict || !ctrl[CTRL_EN_BIT]) begin
            o.gen_status = GS_STATE_CONFLICT;
        end else if (r.cond.param_invalid) begin
            o.gen_status = GS_INVALID_PARAM;
        end else if (r.cond.attr_value_bad) begin
            o.gen_status = GS_ATTR_VALUE;
        end else if (r.cond.attr_list_err) begin
            o.gen_status = GS_ATTR_LIST;
        end else if (r.cond.already_in_mode) begin
            o.gen_status = GS_ALREADY_MODE;
        end else if (r.cond.already_exists) begin
            o.gen_status = GS_EXISTS;
        end else if (r.cond.not_settable) begin
            o.gen_status = GS_NOT_SETTABLE;
        end else if (r.cond.partial_xfer) begin
            o.gen_status = GS_PARTIAL;
        end else begin
            o.gen_status = GS_SUCCESS;
            o.has_data = 1'b1;
            if (or_path) begin
                o.data = (|errs) ? FLAG_ERROR : FLAG_NORMAL;
            end else if (r.attribute_id == ATTR_NORMAL_FLAG) begin
                o.data = errs[idx] ? FLAG_ERROR : FLAG_NORMAL;
            end else begin
                o.data = causes[{idx, 3'b000} +: 8];
            end
        end
        return o;
    endfunction : tosr_decode

    assign req_ready_o = !rsp_valid_q;
    assign req_fire = req_valid_i && req_ready_o && ce_i;
    assign rsp_fire = rsp_valid_q && rsp_ready_i && ce_i;
    assign rsp_d = tosr_decode(req_i, err_s, cause_s, ctrl_q);
    assign rsp_valid_o = rsp_valid_q;
    assign rsp_o = rsp_q;
    assign req_idx = req_i.instance_id[1:0] - 2'd1;
    assign sel_err = err_s[req_idx];
    assign sel_cause = cause_s[{req_idx, 3'b000} +: 8];

    // Reply holding register
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rsp_valid_q <= 1'b0;
            rsp_q <= '{gen_status: GS_SUCCESS, add_status: ADD_NONE, data: 8'h00,
                       has_data: 1'b0};
        end else if (req_fire) begin
            rsp_valid_q <= 1'b1;
            rsp_q <= rsp_d;
        end else if (rsp_fire) begin
            rsp_valid_q <= 1'b0;
        end
    end

    // Activity counters and last status
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            req_cnt_q <= 32'h0000_0000;
            err_cnt_q <= 32'h0000_0000;
            last_gs_q <= GS_SUCCESS;
        end else if (ce_i) begin
            if (req_fire) begin
                req_cnt_q <= clr_cnt ? 32'h0000_0001 : req_cnt_q + 32'h0000_0001;
                if (rsp_d.gen_status != GS_SUCCESS) begin
                    err_cnt_q <= clr_cnt ? 32'h0000_0001 : err_cnt_q + 32'h0000_0001;
                end else if (clr_cnt) begin
                    err_cnt_q <= 32'h0000_0000;
                end
                last_gs_q <= rsp_d.gen_status;
            end else if (clr_cnt) begin
                req_cnt_q <= 32'h0000_0000;
                err_cnt_q <= 32'h0000_0000;
            end
        end
    end

    // AXI4-Lite write side
    logic aw_got_q;
    logic w_got_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic aw_fire;
    logic w_fire;
    logic wr_go;

    assign s_axi_awready = !aw_got_q && !bvalid_q;
    assign s_axi_wready = !w_got_q && !bvalid_q;
    assign aw_fire = s_axi_awvalid && s_axi_awready && ce_i;
    assign w_fire = s_axi_wvalid && s_axi_wready && ce_i;
    assign wr_go = aw_got_q && w_got_q && !bvalid_q && ce_i;
    assign clr_cnt = wr_go && (awaddr_q == REG_CTRL) && wstrb_q[0] && wdata_q[CTRL_CLR_BIT];
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (ce_i) begin
            if (aw_fire) begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (w_fire) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= (awaddr_q == REG_CTRL) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Control register
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ctrl_q <= CTRL_RST;
        end else if (wr_go && (awaddr_q == REG_CTRL) && wstrb_q[0]) begin
            ctrl_q <= wdata_q[1:0];
        end
    end

    // AXI4-Lite read side
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (ce_i) begin
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_q <= 1'b1;
                rresp_q <= RESP_OKAY;
                case (s_axi_araddr)
                    REG_CTRL: rdata_q <= {30'h0000_0000, ctrl_q};
                    REG_STATUS: begin
                        rdata_q <= 32'h0000_0000;
                        rdata_q[STAT_OR_BIT] <= |err_s;
                        rdata_q[STAT_FLAGS_LSB +: 4] <= err_s;
                        rdata_q[STAT_GS_LSB +: 8] <= last_gs_q;
                    end
                    REG_REQ_CNT: rdata_q <= req_cnt_q;
                    REG_ERR_CNT: rdata_q <= err_cnt_q;
                    REG_CAUSE: rdata_q <= cause_s;
                    default: begin
                        rdata_q <= 32'h0000_0000;
                        rresp_q <= RESP_SLVERR;
                    end
                endcase
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    logic clean_get;
    assign clean_get = (req_i.cond == '0) && ctrl_q[CTRL_EN_BIT] && !ctrl_q[CTRL_BUSY_BIT]
        && (req_i.service == SVC_GET_SINGLE);

    sequence s_fire;
        req_fire;
    endsequence

    sequence s_clean_fire;
        req_fire && clean_get;
    endsequence

    sequence s_ok_data;
        rsp_valid_o && rsp_o.has_data && (rsp_o.gen_status == GS_SUCCESS);
    endsequence

    chk_flag_read: assert property (
        s_clean_fire ##0 (req_i.class_id == CLS_TEST_OUT && req_i.attribute_id == ATTR_NORMAL_FLAG
        && req_i.instance_id >= INST_FIRST && req_i.instance_id <= INST_LAST)
        |=> s_ok_data ##0 (rsp_o.data == {7'h00, $past(sel_err)}))
        else $error("normal flag reply wrong");

    chk_cause_read: assert property (
        s_clean_fire ##0 (req_i.class_id == CLS_TEST_OUT && req_i.attribute_id == ATTR_ERR_CAUSE
        && req_i.instance_id >= INST_FIRST && req_i.instance_id <= INST_LAST)
        |=> s_ok_data ##0 (rsp_o.data == $past(sel_cause)))
        else $error("cause reply wrong");

    chk_or_read: assert property (
        s_clean_fire ##0 (req_i.class_id == CLS_TEST_OR && req_i.instance_id == INST_OR
        && req_i.attribute_id == ATTR_OR_FLAG)
        |=> s_ok_data ##0 (rsp_o.data == {7'h00, |$past(err_s)}))
        else $error("combined flag reply wrong");
    chk_reply_hold: assert property (
        rsp_valid_o && !(rsp_ready_i && ce_i) |=> rsp_valid_o && $stable(rsp_o))
        else $error("reply dropped before taken");
    chk_add_status: assert property (
        rsp_valid_o |-> rsp_o.add_status == ADD_NONE)
        else $error("additional status not FF");
    chk_conn_lost: assert property (
        s_fire ##0 req_i.cond.conn_lost |=> rsp_o.gen_status == GS_CONN_LOST && !rsp_o.has_data)
        else $error("connection lost not 07");
    chk_path_seg: assert property (
        s_fire ##0 (!req_i.cond.conn_lost && !req_i.cond.conn_fail && req_i.cond.path_seg_err)
        |=> rsp_o.gen_status == GS_PATH_SEG && !rsp_o.has_data)
        else $error("path segment error not 04");
    chk_bad_inst: assert property (
        s_clean_fire ##0 (req_i.class_id == CLS_TEST_OUT && req_i.instance_id > INST_LAST)
        |=> rsp_o.gen_status == GS_DEST_UNKNOWN && !rsp_o.has_data)
        else $error("bad instance not 05");
    chk_bad_attr: assert property (
        s_clean_fire ##0 (req_i.class_id == CLS_TEST_OR && req_i.attribute_id != ATTR_OR_FLAG)
        |=> rsp_valid_o && rsp_o.gen_status != GS_SUCCESS && !rsp_o.has_data)
        else $error("unlisted attribute accepted");
    chk_disabled: assert property (
        s_fire ##0 (req_i.cond == '0 && !ctrl_q[CTRL_EN_BIT] && !ctrl_q[CTRL_BUSY_BIT]
        && req_i.service == SVC_GET_SINGLE && req_i.class_id == CLS_TEST_OR
        && req_i.instance_id == INST_OR && req_i.attribute_id == ATTR_OR_FLAG)
        |=> rsp_o.gen_status == GS_STATE_CONFLICT)
        else $error("disabled responder not 0C");
    chk_param_code: assert property (
        rsp_valid_o |-> rsp_o.gen_status != 8'h03)
        else $error("old parameter code used");
    chk_axi_read: assert property (
        s_axi_arvalid && s_axi_arready && ce_i |=> s_axi_rvalid)
        else $error("read answer late");
endmodule : tosr_top

// ==== shared/tosr_pkg.sv ====
// Purpose: Shared constants and carriers for the test output status responder.
// Assumes: Requests arrive already parsed into service, class, instance and attribute.
// Notes: Register offsets are byte addresses on a 32-bit AXI4-Lite slave.
package tosr_pkg;

    // Request path and service codes
    localparam logic [7:0] SVC_GET_SINGLE = 8'h0e;
    localparam logic [15:0] CLS_TEST_OUT = 16'h0307;
    localparam logic [15:0] CLS_TEST_OR = 16'h0308;
    localparam logic [7:0] INST_FIRST = 8'h01;
    localparam logic [7:0] INST_LAST = 8'h04;
    localparam logic [7:0] INST_OR = 8'h01;
    localparam logic [7:0] ATTR_NORMAL_FLAG = 8'h68;
    localparam logic [7:0] ATTR_ERR_CAUSE = 8'h76;
    localparam logic [7:0] ATTR_OR_FLAG = 8'h69;

    // Flag data values
    localparam logic [7:0] FLAG_NORMAL = 8'h00;
    localparam logic [7:0] FLAG_ERROR = 8'h01;

    // General status codes
    localparam logic [7:0] GS_SUCCESS = 8'h00;
    localparam logic [7:0] GS_CONN_FAIL = 8'h01;
    localparam logic [7:0] GS_RESOURCE = 8'h02;
    localparam logic [7:0] GS_PATH_SEG = 8'h04;
    localparam logic [7:0] GS_DEST_UNKNOWN = 8'h05;
    localparam logic [7:0] GS_PARTIAL = 8'h06;
    localparam logic [7:0] GS_CONN_LOST = 8'h07;
    localparam logic [7:0] GS_SVC_UNSUPP = 8'h08;
    localparam logic [7:0] GS_ATTR_VALUE = 8'h09;
    localparam logic [7:0] GS_ATTR_LIST = 8'h0a;
    localparam logic [7:0] GS_ALREADY_MODE = 8'h0b;
    localparam logic [7:0] GS_STATE_CONFLICT = 8'h0c;
    localparam logic [7:0] GS_EXISTS = 8'h0d;
    localparam logic [7:0] GS_NOT_SETTABLE = 8'h0e;
    localparam logic [7:0] GS_PRIVILEGE = 8'h0f;
    localparam logic [7:0] GS_INVALID_PARAM = 8'h20;
    localparam logic [7:0] ADD_NONE = 8'hff;

    // Register map
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_REQ_CNT = 8'h08;
    localparam logic [7:0] REG_ERR_CNT = 8'h0c;
    localparam logic [7:0] REG_CAUSE = 8'h10;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_BUSY_BIT = 1;
    localparam int CTRL_CLR_BIT = 2;
    localparam logic [1:0] CTRL_RST = 2'h1;
    localparam int STAT_OR_BIT = 0;
    localparam int STAT_FLAGS_LSB = 4;
    localparam int STAT_GS_LSB = 8;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Conditions reported by the message layer in front of this block
    typedef struct packed {
        logic conn_lost;
        logic conn_fail;
        logic path_seg_err;
        logic resource_busy;
        logic privilege_fail;
        logic state_conflict;
        logic param_invalid;
        logic attr_value_bad;
        logic attr_list_err;
        logic already_in_mode;
        logic already_exists;
        logic not_settable;
        logic partial_xfer;
    } tosr_cond_t;

    typedef struct packed {
        logic [7:0] service;
        logic [15:0] class_id;
        logic [7:0] instance_id;
        logic [7:0] attribute_id;
        tosr_cond_t cond;
    } tosr_req_t;

    typedef struct packed {
        logic [7:0] gen_status;
        logic [7:0] add_status;
        logic [7:0] data;
        logic has_data;
    } tosr_rsp_t;

endpackage : tosr_pkg

// ==== verif/tosr_client.sv ====
// Purpose: Far-side client model that takes replies, promptly or slowly.
// Assumes: Replies stand until taken; one request outstanding at a time.
// Notes: In slow mode ready rises only after the reply has waited three cycles.
`timescale 1ns/1ps
module tosr_client (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Control
    input wire logic slow_i,
    // Reply handshake
    input wire logic rsp_valid_i,
    output logic rsp_ready_o
);
    logic [1:0] wait_q;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !rsp_valid_i || rsp_ready_o) begin
            wait_q <= 2'h0;
        end else if (wait_q != 2'h3) begin
            wait_q <= wait_q + 2'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rsp_ready_o <= 1'b0;
        end else begin
            rsp_ready_o <= slow_i ? (rsp_valid_i && wait_q == 2'h2 && !rsp_ready_o) : 1'b1;
        end
    end
endmodule : tosr_client

// ==== verif/tosr_top_test.sv ====
// Purpose: Self-checking bench for the test output status responder.
// Assumes: Clock enable held high; replies taken by the client model.
// Notes: Register access goes through AXI4-Lite tasks.
`timescale 1ns/1ps
module tosr_top_test;
    import tosr_pkg::*;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [3:0] out_err_i = 4'h0;
    logic [31:0] out_cause_i = 32'h0;
    logic req_valid_i = 1'b0;
    tosr_req_t req_i = '0;
    logic req_ready_o, rsp_valid_o, rsp_ready, slow = 1'b0;
    tosr_rsp_t rsp_o;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    int n_mismatch = 0, checked = 0, cycles = 0;
    logic [7:0] gs_tab [0:12] = '{GS_PARTIAL, GS_NOT_SETTABLE, GS_EXISTS, GS_ALREADY_MODE,
        GS_ATTR_LIST, GS_ATTR_VALUE, GS_INVALID_PARAM, GS_STATE_CONFLICT, GS_PRIVILEGE,
        GS_RESOURCE, GS_PATH_SEG, GS_CONN_FAIL, GS_CONN_LOST};

    tosr_top tosr_top_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
        .out_err_i(out_err_i), .out_cause_i(out_cause_i), .req_valid_i(req_valid_i),
        .req_i(req_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o),
        .rsp_ready_i(rsp_ready), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp));

    tosr_client tosr_client_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .slow_i(slow),
        .rsp_valid_i(rsp_valid_o), .rsp_ready_o(rsp_ready));

    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic give_verdict;
        if (n_mismatch == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict

    always @(posedge clk_i) begin
        cycles++;
        if (cycles >= 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        while (aw || w) begin
            @(posedge clk_i);
            if (aw && s_axi_awready === 1'b1) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready === 1'b1) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        do @(posedge clk_i); while (s_axi_bvalid !== 1'b1);
        check(s_axi_bresp, resp);
        s_axi_bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        do @(posedge clk_i); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge clk_i); while (s_axi_rvalid !== 1'b1);
        check(s_axi_rdata, d);
        check(s_axi_rresp, resp);
        s_axi_rready <= 1'b0;
    endtask : axi_rd

    task automatic send(input logic [7:0] svc, input logic [15:0] cls, input logic [7:0] inst,
        input logic [7:0] attr, input logic [12:0] cnd, input logic [7:0] gs,
        input logic [7:0] data, input logic hd);
        req_valid_i <= 1'b1;
        req_i <= {svc, cls, inst, attr, cnd};
        do @(posedge clk_i); while (req_ready_o !== 1'b1);
        req_valid_i <= 1'b0;
        do @(posedge clk_i); while (!(rsp_valid_o === 1'b1 && rsp_ready === 1'b1));
        check(rsp_o.gen_status, gs);
        check(rsp_o.add_status, ADD_NONE);
        check(rsp_o.has_data, hd);
        if (hd) begin
            check(rsp_o.data, data);
        end
    endtask : send

    initial begin
        logic [7:0] cb;
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        axi_rd(REG_CTRL, 32'h1, RESP_OKAY);
        out_err_i <= 4'h5;
        out_cause_i <= 32'h06_00_02_05;
        repeat (4) @(posedge clk_i);
        for (int i = 1; i <= 4; i++) begin
            cb = out_cause_i[8*(i-1) +: 8];
            send(SVC_GET_SINGLE, CLS_TEST_OUT, 8'(i), ATTR_NORMAL_FLAG, 13'h0, 8'h00,
                {7'h0, out_err_i[i-1]}, 1'b1);
            send(SVC_GET_SINGLE, CLS_TEST_OUT, 8'(i), ATTR_ERR_CAUSE, 13'h0, 8'h00, cb,
                1'b1);
        end
        send(SVC_GET_SINGLE, CLS_TEST_OR, 8'h01, ATTR_OR_FLAG, 13'h0, 8'h00, 8'h01, 1'b1);
        axi_rd(REG_STATUS, 32'h0000_0051, RESP_OKAY);
        axi_rd(REG_CAUSE, 32'h0600_0205, RESP_OKAY);
        axi_rd(REG_REQ_CNT, 32'h0000_0009, RESP_OKAY);
        axi_rd(REG_ERR_CNT, 32'h0000_0000, RESP_OKAY);
        out_err_i <= 4'h0;
        repeat (4) @(posedge clk_i);
        send(SVC_GET_SINGLE, CLS_TEST_OR, 8'h01, ATTR_OR_FLAG, 13'h0, 8'h00, 8'h00, 1'b1);
        send(SVC_GET_SINGLE, CLS_TEST_OUT, 8'h05, ATTR_NORMAL_FLAG, 13'h0, 8'h05, 8'h0, 1'b0);
        send(SVC_GET_SINGLE, CLS_TEST_OUT, 8'h00, ATTR_ERR_CAUSE, 13'h0, 8'h05, 8'h0, 1'b0);
        send(SVC_GET_SINGLE, CLS_TEST_OUT, 8'h02, 8'h69, 13'h0, 8'h05, 8'h0, 1'b0);
        send(SVC_GET_SINGLE, CLS_TEST_OR, 8'h02, ATTR_OR_FLAG, 13'h0, 8'h05, 8'h0, 1'b0);
        send(SVC_GET_SINGLE, CLS_TEST_OR, 8'h01, ATTR_NORMAL_FLAG, 13'h0, 8'h05, 8'h0,
            1'b0);
        send(SVC_GET_SINGLE, 16'h0309, 8'h01, ATTR_OR_FLAG, 13'h0, 8'h05, 8'h0, 1'b0);
        send(8'h10, CLS_TEST_OUT, 8'h01, ATTR_NORMAL_FLAG, 13'h0, 8'h08, 8'h0, 1'b0);
        for (int i = 0; i < 13; i++) begin
            slow <= i[0];
            send(SVC_GET_SINGLE, CLS_TEST_OUT, 8'h01, ATTR_NORMAL_FLAG, 13'(1 << i), gs_tab[i],
                8'h0, 1'b0);
        end
        slow <= 1'b0;
        send(SVC_GET_SINGLE, CLS_TEST_OUT, 8'h01, ATTR_NORMAL_FLAG, 13'h1fff, 8'h07, 8'h0,
            1'b0);
        axi_wr(REG_CTRL, 32'h3, RESP_OKAY);
        send(SVC_GET_SINGLE, CLS_TEST_OUT, 8'h01, ATTR_NORMAL_FLAG, 13'h0, 8'h02, 8'h0, 1'b0);
        axi_wr(REG_CTRL, 32'h0, RESP_OKAY);
        send(SVC_GET_SINGLE, CLS_TEST_OR, 8'h01, ATTR_OR_FLAG, 13'h0, 8'h0c, 8'h0, 1'b0);
        axi_rd(REG_REQ_CNT, 32'h0000_0021, RESP_OKAY);
        axi_rd(REG_ERR_CNT, 32'h0000_0017, RESP_OKAY);
        axi_wr(REG_CTRL, 32'h5, RESP_OKAY);
        axi_wr(REG_STATUS, 32'h1, RESP_SLVERR);
        axi_rd(8'h40, 32'h0, RESP_SLVERR);
        axi_rd(REG_CTRL, 32'h1, RESP_OKAY);
        axi_rd(REG_STATUS, 32'h0000_0c00, RESP_OKAY);
        axi_rd(REG_ERR_CNT, 32'h0000_0000, RESP_OKAY);
        send(SVC_GET_SINGLE, CLS_TEST_OUT, 8'h04, ATTR_NORMAL_FLAG, 13'h0, 8'h00, 8'h00, 1'b1);
        axi_rd(REG_REQ_CNT, 32'h0000_0001, RESP_OKAY);
        give_verdict();
    end
endmodule : tosr_top_test
